// ---- rtl/hce_edge_gen.sv ----
// Chosen here: the AXI4-Lite slave port.
`timescale 1ns/100ps
// Function
// - during vertical shift, clock two holds the level of its bit 6
// - during vertical shift, clock three holds the level of its bit 6
// - clock two bits 5..3 pick the falling-edge phase, codes 0..7
// - clock two falls on the rising edge of the selected phase
// - clock two bits 2..0 pick the rising-edge phase, codes 0..7
// - clock two rises on the rising edge of the selected phase
// - complemented phases, inverse of each base phase, are also selectable
// - clock two register is read/write at 2Ah, resets to 7Ah, bit 7 reserved
// - clock three register is read/write at 2Bh, resets to 4Ch, bit 7 reserved
module hce_edge_gen
   import hce_pkg::*;
(
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // axi4-lite write address
   input wire logic [HCE_ADDR_W-1:0] s_axi_awaddr,
   input wire logic [2:0] s_axi_awprot,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   // axi4-lite write data
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   // axi4-lite write response
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // axi4-lite read address
   input wire logic [HCE_ADDR_W-1:0] s_axi_araddr,
   input wire logic [2:0] s_axi_arprot,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   // axi4-lite read data
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // timing generator side
   input wire logic [HCE_NUM_PHASE-1:0] internal_phase,
   input wire logic vshift_active,
   // ccd horizontal clocks
   output logic horiz_clock_two,
   output logic horiz_clock_three
);

   // ----------------------------------------
   // registers
   // ----------------------------------------
   hce_edge_cfg_t two_cfg_q;
   hce_edge_cfg_t three_cfg_q;
   hce_comp_cfg_t [HCE_NUM_CLK-1:0] comp_cfg_q;
   hce_edge_cfg_t [HCE_NUM_CLK-1:0] edge_cfg;

   logic aw_held_q;
   logic w_held_q;
   logic [HCE_ADDR_W-1:0] awaddr_q;
   logic [7:0] wbyte_q;
   logic wlane_q;
   logic bvalid_q;
   logic [1:0] bresp_q;
   logic rvalid_q;
   logic [31:0] rdata_q;
   logic [1:0] rresp_q;

   // ----------------------------------------
   // input synchronisers
   // ----------------------------------------
   logic [HCE_NUM_PHASE-1:0] ph_s1_q;
   logic [HCE_NUM_PHASE-1:0] ph_s2_q;
   logic [HCE_NUM_PHASE-1:0] ph_s3_q;
   logic vs_s1_q;
   logic vs_s2_q;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ph_s1_q <= '0;
         ph_s2_q <= '0;
         ph_s3_q <= '0;
         vs_s1_q <= 1'b0;
         vs_s2_q <= 1'b0;
      end else begin
         ph_s1_q <= internal_phase;
         ph_s2_q <= ph_s1_q;
         ph_s3_q <= ph_s2_q;
         vs_s1_q <= vshift_active;
         vs_s2_q <= vs_s1_q;
      end
   end

   // rising and falling edges of each base phase; a falling edge of a base
   // phase is the rising edge of its complement
   wire [HCE_NUM_PHASE-1:0] ph_rise = ph_s2_q & ~ph_s3_q;
   wire [HCE_NUM_PHASE-1:0] ph_fall = ~ph_s2_q & ph_s3_q;

   // ----------------------------------------
   // write channel
   // ----------------------------------------
   wire aw_hs = s_axi_awvalid && s_axi_awready;
   wire w_hs = s_axi_wvalid && s_axi_wready;
   wire wr_go = aw_held_q && w_held_q && !bvalid_q;
   wire [HCE_ADDR_W-1:0] wr_word = {awaddr_q[HCE_ADDR_W-1:2], 2'b00};
   wire wr_two = wr_word == HCE_ADDR_TWO;
   wire wr_three = wr_word == HCE_ADDR_THREE;
   wire wr_comp = wr_word == HCE_ADDR_COMP;
   wire wr_stat = wr_word == HCE_ADDR_STAT;
   wire wr_hit = wr_two || wr_three || wr_comp || wr_stat;
   wire wr_en = wr_go && wlane_q;

   assign s_axi_awready = !aw_held_q;
   assign s_axi_wready = !w_held_q;
   assign s_axi_bvalid = bvalid_q;
   assign s_axi_bresp = bresp_q;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held_q <= 1'b0;
         awaddr_q <= '0;
      end else if (aw_hs) begin
         aw_held_q <= 1'b1;
         awaddr_q <= s_axi_awaddr;
      end else if (wr_go) begin
         aw_held_q <= 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         w_held_q <= 1'b0;
         wbyte_q <= '0;
         wlane_q <= 1'b0;
      end else if (w_hs) begin
         w_held_q <= 1'b1;
         wbyte_q <= s_axi_wdata[7:0];
         wlane_q <= s_axi_wstrb[0];
      end else if (wr_go) begin
         w_held_q <= 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bvalid_q <= 1'b0;
         bresp_q <= HCE_RESP_OKAY;
      end else if (wr_go) begin
         bvalid_q <= 1'b1;
         bresp_q <= wr_hit ? HCE_RESP_OKAY : HCE_RESP_SLVERR;
      end else if (s_axi_bready) begin
         bvalid_q <= 1'b0;
      end
   end

   // ----------------------------------------
   // control registers
   // ----------------------------------------
   // bit 7 is reserved: it is never stored and reads as zero
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         two_cfg_q <= hce_edge_cfg_t'(HCE_RST_TWO & 8'h7f);
      end else if (wr_en && wr_two) begin
         two_cfg_q <= hce_edge_cfg_t'({1'b0, wbyte_q[6:0]});
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         three_cfg_q <= hce_edge_cfg_t'(HCE_RST_THREE & 8'h7f);
      end else if (wr_en && wr_three) begin
         three_cfg_q <= hce_edge_cfg_t'({1'b0, wbyte_q[6:0]});
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         comp_cfg_q <= HCE_RST_COMP;
      end else if (wr_en && wr_comp) begin
         comp_cfg_q <= wbyte_q[3:0];
      end
   end

   assign edge_cfg[0] = two_cfg_q;
   assign edge_cfg[1] = three_cfg_q;

   // ----------------------------------------
   // read channel
   // ----------------------------------------
   wire ar_hs = s_axi_arvalid && s_axi_arready;
   wire [HCE_ADDR_W-1:0] rd_word = {s_axi_araddr[HCE_ADDR_W-1:2], 2'b00};
   wire rd_two = rd_word == HCE_ADDR_TWO;
   wire rd_three = rd_word == HCE_ADDR_THREE;
   wire rd_comp = rd_word == HCE_ADDR_COMP;
   wire rd_stat = rd_word == HCE_ADDR_STAT;
   wire rd_hit = rd_two || rd_three || rd_comp || rd_stat;
   wire [7:0] stat_byte = {5'h00, vs_s2_q, horiz_clock_three, horiz_clock_two};
   wire [7:0] rd_byte = rd_two ? two_cfg_q :
                        rd_three ? three_cfg_q :
                        rd_comp ? {4'h0, comp_cfg_q} :
                        rd_stat ? stat_byte : 8'h00;

   assign s_axi_arready = !rvalid_q;
   assign s_axi_rvalid = rvalid_q;
   assign s_axi_rdata = rdata_q;
   assign s_axi_rresp = rresp_q;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rvalid_q <= 1'b0;
         rdata_q <= '0;
         rresp_q <= HCE_RESP_OKAY;
      end else if (ar_hs) begin
         rvalid_q <= 1'b1;
         rdata_q <= {24'h000000, rd_byte};
         rresp_q <= rd_hit ? HCE_RESP_OKAY : HCE_RESP_SLVERR;
      end else if (s_axi_rready) begin
         rvalid_q <= 1'b0;
      end
   end

   // ----------------------------------------
   // edge placement, one slice per clock
   // ----------------------------------------
   logic [HCE_NUM_CLK-1:0] hclk_q;

   for (genvar k = 0; k < HCE_NUM_CLK; k++) begin : g_clk
      wire fall_base = comp_cfg_q[k].fall_comp ?
                       ph_fall[edge_cfg[k].fall_phase] :
                       ph_rise[edge_cfg[k].fall_phase];
      wire rise_base = comp_cfg_q[k].rise_comp ?
                       ph_fall[edge_cfg[k].rise_phase] :
                       ph_rise[edge_cfg[k].rise_phase];
      wire hold = edge_cfg[k].hold_level;
      logic hclk_d;

      // vertical shift hold beats edges; a rise wins over a fall in one cycle
      always_comb begin
         if (vs_s2_q) begin
            hclk_d = hold;
         end else if (rise_base) begin
            hclk_d = 1'b1;
         end else if (fall_base) begin
            hclk_d = 1'b0;
         end else begin
            hclk_d = hclk_q[k];
         end
      end

      always_ff @(posedge aclk) begin
         if (!aresetn) begin
            hclk_q[k] <= 1'b0;
         end else begin
            hclk_q[k] <= hclk_d;
         end
      end
   end

   assign horiz_clock_two = hclk_q[0];
   assign horiz_clock_three = hclk_q[1];

endmodule

// ---- rtl/hce_pkg.sv ----
package hce_pkg;

   // ----------------------------------------
   // register indices and byte addresses
   // ----------------------------------------
   localparam logic [7:0] HCE_IDX_TWO = 8'h2a;
   localparam logic [7:0] HCE_IDX_THREE = 8'h2b;
   localparam logic [7:0] HCE_IDX_COMP = 8'h30;
   localparam logic [7:0] HCE_IDX_STAT = 8'h31;
   localparam int HCE_ADDR_W = 10;
   localparam logic [9:0] HCE_ADDR_TWO = {HCE_IDX_TWO, 2'b00};
   localparam logic [9:0] HCE_ADDR_THREE = {HCE_IDX_THREE, 2'b00};
   localparam logic [9:0] HCE_ADDR_COMP = {HCE_IDX_COMP, 2'b00};
   localparam logic [9:0] HCE_ADDR_STAT = {HCE_IDX_STAT, 2'b00};

   // ----------------------------------------
   // reset values
   // ----------------------------------------
   localparam logic [7:0] HCE_RST_TWO = 8'h7a;
   localparam logic [7:0] HCE_RST_THREE = 8'h4c;
   localparam logic [3:0] HCE_RST_COMP = 4'h0;

   // ----------------------------------------
   // field layout
   // ----------------------------------------
   localparam int HCE_HOLD_BIT = 6;
   localparam int HCE_FALL_LSB = 3;
   localparam int HCE_RISE_LSB = 0;
   localparam int HCE_NUM_PHASE = 8;
   localparam int HCE_NUM_CLK = 2;

   // ----------------------------------------
   // bus answers
   // ----------------------------------------
   localparam logic [1:0] HCE_RESP_OKAY = 2'h0;
   localparam logic [1:0] HCE_RESP_SLVERR = 2'h2;

   typedef struct packed {
      logic reserved;
      logic hold_level;
      logic [2:0] fall_phase;
      logic [2:0] rise_phase;
   } hce_edge_cfg_t;

   typedef struct packed {
      logic fall_comp;
      logic rise_comp;
   } hce_comp_cfg_t;

endpackage

// ---- dv/hce_phase_src.sv ----
`timescale 1ns/100ps
module hce_phase_src (
   // clock
   input wire logic aclk,
   // eight phases, 32 cycles long, each 4 cycles after the last
   output logic [7:0] internal_phase,
   output logic [4:0] phase_pos
);
   initial phase_pos = 5'h0;
   always @(posedge aclk) phase_pos <= phase_pos + 5'h1;
   always_comb begin
      for (int i = 0; i < 8; i++) internal_phase[i] = 5'(phase_pos - 5'(4 * i)) < 5'h10;
   end
endmodule

// ---- dv/hce_edge_gen_assertions.sv ----
`timescale 1ns/100ps
module hce_chk (
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // register bus
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // vertical shift and horizontal clocks
   input wire logic vshift_active,
   input wire logic horiz_clock_two,
   input wire logic horiz_clock_three
);
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   property p_rst; $rose(aresetn) |-> !s_axi_bvalid && !s_axi_rvalid && !horiz_clock_two; endproperty
   a_rst: assert property (p_rst) else $error("state after reset");
   property p_wlat; s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid; endproperty
   a_wlat: assert property (p_wlat) else $error("write answer late");
   property p_rlat; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
   a_rlat: assert property (p_rlat) else $error("read answer late");
   property p_bhold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp); endproperty
   a_bhold: assert property (p_bhold) else $error("write answer dropped");
   property p_rhold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata); endproperty
   a_rhold: assert property (p_rhold) else $error("read answer dropped");
   property p_rzero; s_axi_rvalid |-> s_axi_rdata[31:7] == 25'h0; endproperty
   a_rzero: assert property (p_rzero) else $error("reserved bits set");
   property p_arrdy; s_axi_rvalid |-> !s_axi_arready; endproperty
   a_arrdy: assert property (p_arrdy) else $error("read taken while busy");
   property p_hold; vshift_active [*6] |-> $stable(horiz_clock_two) && $stable(horiz_clock_three); endproperty
   a_hold: assert property (p_hold) else $error("clock moved in vertical shift");
endmodule
bind hce_edge_gen hce_chk u_chk (.*);

// ---- dv/hce_edge_gen_test.sv ----
`timescale 1ns/100ps
module hce_edge_gen_test
   import hce_pkg::*;
;
   typedef struct packed {logic [9:0] a; logic [7:0] w; logic [7:0] r; logic [1:0] e;} hce_row_t;
   logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, vshift_active;
   logic horiz_clock_two, horiz_clock_three, mon, have, cm;
   logic [9:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic [2:0] s_axi_awprot = 3'h0, s_axi_arprot = 3'h0, rs[2], fs[2];
   logic [3:0] s_axi_wstrb = 4'h1;
   logic [1:0] s_axi_bresp, s_axi_rresp, hp;
   logic [7:0] internal_phase;
   logic [4:0] pos, lat, ref_lat;
   int n_errors = 0, num_checks = 0, n_edge = 0;
   wire [1:0] hc = {horiz_clock_three, horiz_clock_two};
   hce_row_t rows[4] = '{'{HCE_ADDR_TWO, 8'hff, 8'h7f, HCE_RESP_OKAY},
      '{HCE_ADDR_THREE, 8'h80, 8'h00, HCE_RESP_OKAY},
      '{HCE_ADDR_THREE, 8'h35, 8'h35, HCE_RESP_OKAY}, '{10'h3fc, 8'h55, 8'h00, HCE_RESP_SLVERR}};
   hce_edge_gen u_dut (.*);
   hce_phase_src u_src (.aclk(aclk), .internal_phase(internal_phase), .phase_pos(pos));
   initial begin
      aclk = 1'b0;
      forever #10 aclk = ~aclk;
   end
   task automatic finish_test();
      if (n_errors == 0 && num_checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      num_checks++;
      if (g !== e) begin
         n_errors++;
         $display("BAD t=%0t got %h exp %h", $time, g, e);
      end
   endtask
   task automatic tick(inout int n);
      n++;
      if (n > 60) begin
         n_errors++;
         finish_test();
      end
      @(posedge aclk);
   endtask
   task automatic wr(input logic [9:0] a, input logic [7:0] d, input logic [1:0] er);
      int n = 0;
      s_axi_awaddr <= a;
      s_axi_wdata <= {24'h0, d};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      tick(n);
      while (!(s_axi_bvalid === 1'b1 && s_axi_bready === 1'b1)) begin
         if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
         if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid === 1'b1) s_axi_bready <= 1'b1;
         tick(n);
      end
      s_axi_bready <= 1'b0;
      chk(32'(s_axi_bresp), 32'(er));
      tick(n);
   endtask
   task automatic rd(input logic [9:0] a, input logic [7:0] e, input logic [1:0] er);
      int n = 0;
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      tick(n);
      while (!(s_axi_rvalid === 1'b1 && s_axi_rready === 1'b1)) begin
         if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid === 1'b1) s_axi_rready <= 1'b1;
         tick(n);
      end
      s_axi_rready <= 1'b0;
      chk(s_axi_rdata, {24'h0, e});
      chk(32'(s_axi_rresp), 32'(er));
      tick(n);
   endtask
   // every edge seen must sit at the same delay after its selected phase
   always @(posedge aclk) begin
      for (int k = 0; k < 2; k++) begin
         if (mon && hc[k] !== hp[k]) begin
            lat = pos - 5'(4 * (hc[k] ? rs[k] : fs[k]) + 16 * cm);
            if (!have) ref_lat = lat;
            have = 1'b1;
            chk(32'(lat), 32'(ref_lat));
            n_edge++;
         end
      end
      hp = hc;
   end
   initial begin
      {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata, vshift_active, mon, have, cm} = '0;
      repeat (3) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      foreach (rows[i]) begin
         wr(rows[i].a, rows[i].w, rows[i].e);
         rd(rows[i].a, rows[i].r, rows[i].e);
      end
      for (int k = 0; k < 9; k++) begin
         @(posedge aclk);
         rs[0] = 3'(k);
         fs[0] = 3'(k + 3);
         rs[1] = 3'(k + 5);
         fs[1] = 3'(k);
         cm = (k == 8);
         wr(HCE_ADDR_TWO, {2'b00, fs[0], rs[0]}, HCE_RESP_OKAY);
         wr(HCE_ADDR_THREE, {2'b00, fs[1], rs[1]}, HCE_RESP_OKAY);
         wr(HCE_ADDR_COMP, {4'h0, {4{cm}}}, HCE_RESP_OKAY);
         rd(HCE_ADDR_COMP, {4'h0, {4{cm}}}, HCE_RESP_OKAY);
         repeat (40) @(posedge aclk);
         mon <= 1'b1;
         repeat (64) @(posedge aclk);
         mon <= 1'b0;
      end
      chk(32'(n_edge), 32'd72);
      chk(32'(ref_lat == 5'd3 || ref_lat == 5'd4), 32'd1);
      for (int h = 0; h < 2; h++) begin
         wr(HCE_ADDR_TWO, {1'b0, h[0], 6'h0c}, HCE_RESP_OKAY);
         wr(HCE_ADDR_THREE, {1'b0, !h[0], 6'h21}, HCE_RESP_OKAY);
         vshift_active <= 1'b1;
         repeat (8) @(posedge aclk);
         repeat (20) begin
            @(posedge aclk);
            chk(32'(hc), {30'h0, !h[0], h[0]});
         end
         rd(HCE_ADDR_STAT, {5'h00, 1'b1, !h[0], h[0]}, HCE_RESP_OKAY);
         vshift_active <= 1'b0;
      end
      aresetn <= 1'b0;
      repeat (3) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      rd(HCE_ADDR_TWO, 8'h7a, HCE_RESP_OKAY);
      rd(HCE_ADDR_THREE, 8'h4c, HCE_RESP_OKAY);
      finish_test();
   end
endmodule
